// >>> include/core_exc_pkg.sv
/*
 * shared constants and carriers for the core exception/priority control block.
 * assumes an apb slave with 32-bit data; registers are 16 bits in the low half.
 */
package core_exc_pkg;
    // register byte offsets
    localparam logic [11:0] CORE_CONTROL_OFS      = 12'h000;
    localparam logic [11:0] INTR_CONTROL_ONE_OFS  = 12'h004;
    localparam logic [11:0] PROC_STATUS_OFS       = 12'h008;

    // core_control field positions
    localparam int VAR_LATENCY_POS   = 15;
    localparam int SIGN_MODE_1_POS   = 13;
    localparam int SIGN_MODE_0_POS   = 12;
    localparam int EARLY_EXIT_POS    = 11;
    localparam int LOOP_DEPTH_LSB    = 8;
    localparam int ACC_A_SAT_POS     = 7;
    localparam int ACC_B_SAT_POS     = 6;
    localparam int SPACE_SAT_POS     = 5;
    localparam int SAT_STYLE_POS     = 4;
    localparam int PRIO_TOP_POS      = 3;
    localparam int ACTIVE_ACC_POS    = 2;
    localparam int ROUND_SEL_POS     = 1;
    localparam int INT_FRAC_POS      = 0;

    // interrupt_control_one field positions
    localparam int NEST_DIS_POS      = 15;
    localparam int OVA_FLAG_POS      = 14;
    localparam int OVB_FLAG_POS      = 13;
    localparam int COVA_FLAG_POS     = 12;
    localparam int COVB_FLAG_POS     = 11;

    // processor status priority field
    localparam int PRIO_LOW_LSB      = 5;

    // reset values and writable masks
    localparam logic [15:0] CORE_CONTROL_RST  = 16'h0020;
    localparam logic [15:0] CORE_CONTROL_WMSK = 16'hB8F3;
    localparam logic [15:0] INTR_ONE_RST      = 16'h0000;
    localparam logic [15:0] INTR_ONE_WMSK     = 16'hFFDE;
    localparam logic [15:0] INTR_FLAG_MSK     = 16'h7800;
    localparam logic [3:0]  PRIO_SEVEN        = 4'h7;

    // apb request carrier
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

    // trap cause event pulses
    typedef struct packed {
        logic accAOverflow;
        logic accBOverflow;
        logic accASevere;
        logic accBSevere;
    } trap_cause_t;
endpackage

// >>> design/sticky_flag.sv
/*
 * one sticky flag: hardware sets, software clears by writing 0.
 * assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps
module sticky_flag
(
    input  wire logic clock,      // system clock
    input  wire logic sys_rst,    // synchronous reset, active high
    input  wire logic setPulse,   // hardware event
    input  wire logic clearPulse, // software write of 0
    output logic      flag        // sticky state
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state_reg;
    flag_state_t state_next;

    // set wins over a clear in the same cycle so no event is lost
    always_comb
    begin
        state_next = state_reg;
        if (setPulse)
            state_next.flag = 1'b1;
        else if (clearPulse)
            state_next.flag = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign flag = state_reg.flag;
endmodule

// >>> design/core_exception_priority_control.sv
/*
 * core exception and interrupt-priority control registers behind an apb slave.
 * assumes the core drives trap cause pulses, loop depth, active accumulator and
 * priority updates on the same clock; apb master on the same clock.
 */
// Behaviour
// - A latency-control bit selects variable (1) or fixed (0) exception latency and resets to 0.
// - The upper priority bit reads 1 when the full priority level exceeds 7, else 0.
// - The four-bit priority is the upper bit above the three low bits of the processor status register.
// - The core control register resets to zero except the data-space-write saturation enable, which resets to 1.
// - The nesting-disable control blocks interrupt preemption when 1, allows it when 0, and resets to 0.
// - Separate flags record overflow of A, overflow of B, severe overflow of A and severe overflow of B.
`timescale 1ns/100ps
module core_exception_priority_control
    import core_exc_pkg::*;
(
    input  wire logic        clock,          // 10 MHz system clock
    input  wire logic        sys_rst,        // synchronous reset, active high
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire trap_cause_t trapCause,      // one-cycle trap cause pulses
    input  wire logic [2:0]  loopDepth,      // live loop nesting depth
    input  wire logic        activeAcc,      // live active accumulator
    input  wire logic        prioLoad,       // core loads a new priority
    input  wire logic [3:0]  prioLoadValue,  // priority to load
    input  wire logic        irqPending,     // an interrupt request is waiting
    input  wire logic [3:0]  irqLevel,       // level of the waiting request
    input  wire logic        inService,      // an interrupt is being serviced
    output logic             variableLatency,// exception latency mode
    output logic [3:0]       cpuPriority,    // four-bit priority level
    output logic             preemptAllowed, // waiting request may preempt
    output logic             nestingDisabled // nesting control
);
    typedef struct packed {
        logic [15:0] coreCtl;
        logic        nestDis;
        logic [15:0] intrOther;
        logic [2:0]  prioLow;
        logic [31:0] rdata;
    } exc_state_t;

    exc_state_t  state_reg;
    exc_state_t  state_next;
    apb_req_t    req;
    logic        wrAccess;
    logic        rdAccess;
    logic        hitCore;
    logic        hitIntr;
    logic        hitStat;
    logic        prioTop;
    logic [3:0]  flags;
    logic [15:0] coreView;
    logic [15:0] intrView;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign hitCore  = req.addr == CORE_CONTROL_OFS;
    assign hitIntr  = req.addr == INTR_CONTROL_ONE_OFS;
    assign hitStat  = req.addr == PROC_STATUS_OFS;
    assign wrAccess = req.sel && req.enable && req.write;
    assign rdAccess = req.sel && !req.enable && !req.write;

    // trap cause flags, each one sticky cell; a write of 0 clears it
    localparam int FLAG_POS [4] = '{OVA_FLAG_POS, OVB_FLAG_POS, COVA_FLAG_POS, COVB_FLAG_POS};
    logic [3:0] causeSet;
    assign causeSet = {trapCause.accAOverflow, trapCause.accBOverflow, trapCause.accASevere, trapCause.accBSevere};
    // set beats a same-cycle clear inside each cell, so a trap during the handler's write is kept
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_flag
            sticky_flag u_flag
            (
                .clock      (clock),
                .sys_rst    (sys_rst),
                .setPulse   (causeSet[3-g]),
                .clearPulse (wrAccess && hitIntr && !req.wdata[FLAG_POS[g]]),
                .flag       (flags[3-g])
            );
        end
    endgenerate

    // upper priority bit follows the level held in the core control register
    assign prioTop = state_reg.coreCtl[PRIO_TOP_POS];
    assign cpuPriority = {prioTop, state_reg.prioLow};

    // live read-only fields are folded into the view instead of stored
    always_comb
    begin
        coreView = state_reg.coreCtl;
        coreView[LOOP_DEPTH_LSB +: 3] = loopDepth;
        coreView[ACTIVE_ACC_POS] = activeAcc;
        intrView = state_reg.intrOther & ~INTR_FLAG_MSK;
        intrView[NEST_DIS_POS] = state_reg.nestDis;
        intrView[OVA_FLAG_POS] = flags[3];
        intrView[OVB_FLAG_POS] = flags[2];
        intrView[COVA_FLAG_POS] = flags[1];
        intrView[COVB_FLAG_POS] = flags[0];
    end

    // register writes, priority loads and read data capture
    always_comb
    begin
        state_next = state_reg;
        if (prioLoad)
        begin
            state_next.prioLow = prioLoadValue[2:0];
            state_next.coreCtl[PRIO_TOP_POS] = prioLoadValue > PRIO_SEVEN;
        end
        if (wrAccess && hitCore)
        begin
            state_next.coreCtl = (req.wdata[15:0] & CORE_CONTROL_WMSK)
                               | (state_reg.coreCtl & ~CORE_CONTROL_WMSK);
            state_next.coreCtl[PRIO_TOP_POS] = state_reg.coreCtl[PRIO_TOP_POS]
                                             & req.wdata[PRIO_TOP_POS];
            state_next.coreCtl[LOOP_DEPTH_LSB +: 3] = 3'h0;
            state_next.coreCtl[ACTIVE_ACC_POS] = 1'b0;
            state_next.coreCtl[14] = 1'b0;
        end
        if (wrAccess && hitIntr)
        begin
            state_next.nestDis   = req.wdata[NEST_DIS_POS];
            state_next.intrOther = req.wdata[15:0] & INTR_ONE_WMSK & ~INTR_FLAG_MSK;
        end
        if (wrAccess && hitStat)
            state_next.prioLow = req.wdata[PRIO_LOW_LSB +: 3];
        if (rdAccess)
        begin
            state_next.rdata = 32'h0000_0000;
            if (hitCore)
                state_next.rdata[15:0] = coreView;
            else if (hitIntr)
                state_next.rdata[15:0] = intrView;
            else if (hitStat)
                state_next.rdata[PRIO_LOW_LSB +: 3] = state_reg.prioLow;
        end
    end

    // single state register; reset puts saturation enable at 1
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_reg         <= '0;
            state_reg.coreCtl <= CORE_CONTROL_RST;
        end
        else
            state_reg <= state_next;
    end

    // apb answers in the access cycle; unmapped addresses raise pslverr
    // no wait states: every register is a flop, so the slave never needs to stall
    assign pready  = 1'b1;
    assign pslverr = req.sel && req.enable && !(hitCore || hitIntr || hitStat);
    assign prdata  = state_reg.rdata;

    assign variableLatency = state_reg.coreCtl[VAR_LATENCY_POS];
    assign nestingDisabled = state_reg.nestDis;
    // preemption needs a higher level, and is blocked while an interrupt is in service and nesting is off
    assign preemptAllowed  = irqPending && (irqLevel > cpuPriority)
                           && !(inService && state_reg.nestDis);

    // looks one edge after reset is sampled, so power-up has no history to misread
    property p_rst_value;
        @(posedge clock) sys_rst |=> state_reg.coreCtl == CORE_CONTROL_RST;
    endproperty
    a_rst_value: assert property (p_rst_value) else $error("core control reset value wrong");

    property p_latency;
        @(posedge clock) disable iff (sys_rst)
        wrAccess && hitCore |=> variableLatency == $past(req.wdata[VAR_LATENCY_POS]);
    endproperty
    a_latency: assert property (p_latency) else $error("latency bit not written");

    property p_prio_top;
        @(posedge clock) disable iff (sys_rst)
        prioLoad && !(wrAccess && hitCore) |=> prioTop == ($past(prioLoadValue) > PRIO_SEVEN);
    endproperty
    a_prio_top: assert property (p_prio_top) else $error("upper priority bit wrong");

    property p_prio_join;
        @(posedge clock) disable iff (sys_rst)
        prioLoad && !(wrAccess && (hitCore || hitStat)) |=> cpuPriority == $past(prioLoadValue);
    endproperty
    a_prio_join: assert property (p_prio_join) else $error("priority not formed");

    property p_no_set_top;
        @(posedge clock) disable iff (sys_rst)
        wrAccess && hitCore && !prioLoad && !prioTop |=> !prioTop;
    endproperty
    a_no_set_top: assert property (p_no_set_top) else $error("software set upper priority");

    // gating is checked at the output that the interrupt logic actually sees
    property p_nest_block;
        @(posedge clock) disable iff (sys_rst)
        inService && nestingDisabled |-> !preemptAllowed;
    endproperty
    a_nest_block: assert property (p_nest_block) else $error("nesting not blocked");

    sequence s_cause;
        trapCause.accAOverflow;
    endsequence
    sequence s_flag_held;
        flags[3] [*2];
    endsequence
    property p_cause_set;
        @(posedge clock) disable iff (sys_rst) s_cause |=> flags[3];
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("overflow A flag not set");

    property p_sticky;
        @(posedge clock) disable iff (sys_rst)
        flags[3] && !(wrAccess && hitIntr) |=> s_flag_held or (flags[3] ##0 1'b1);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
endmodule

// >>> sim/core_exception_priority_control_tb_top.sv
/*
 * self-checking bench for the core exception/priority control block.
 * assumes an apb slave that answers with pready and drives the core-side levels itself.
 */
`timescale 1ns/100ps
module core_exception_priority_control_tb_top
    import core_exc_pkg::*;
;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, variableLatency, preemptAllowed, nestingDisabled;
    trap_cause_t trapCause = '0;
    logic [2:0]  loopDepth = 3'h0;
    logic        activeAcc = 1'b0, prioLoad = 1'b0, irqPending = 1'b0, inService = 1'b0;
    logic [3:0]  prioLoadValue = 4'h0, irqLevel = 4'h0, cpuPriority, prioExp, v;
    logic [15:0] ccModel, mask;
    integer      seed = 32'h84783364;
    int          fail_count = 0, n_checks = 0;

    always #50 clock = ~clock;

    core_exception_priority_control uut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trapCause(trapCause), .loopDepth(loopDepth), .activeAcc(activeAcc), .prioLoad(prioLoad),
        .prioLoadValue(prioLoadValue), .irqPending(irqPending), .irqLevel(irqLevel), .inService(inService),
        .variableLatency(variableLatency), .cpuPriority(cpuPriority), .preemptAllowed(preemptAllowed),
        .nestingDisabled(nestingDisabled));

    // core control as software sees it: stored bits, top priority bit and live status
    function automatic logic [31:0] ccView(input logic [15:0] m, input logic [3:0] p);
        ccView = {16'h0000, (m & ~16'h0008) | {5'h00, loopDepth, 4'h0, p > 4'h7, activeAcc, 2'h0}};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // one apb transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic unmapped;
        unmapped = !(a == CORE_CONTROL_OFS || a == INTR_CONTROL_ONE_OFS || a == PROC_STATUS_OFS);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        // no cycle count is assumed; a hung wait is ended by the watchdog
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk("pslverr", {31'h0, unmapped}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic loadPrio(input logic [3:0] p);
        @(posedge clock);
        prioLoad      <= 1'b1;
        prioLoadValue <= p;
        @(posedge clock);
        prioLoad <= 1'b0;
        prioExp = p;
        @(negedge clock);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog: a few hundred cycles are expected, this allows far more
    initial
    begin
        #2000000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        loopDepth <= 3'($random(seed));
        activeAcc <= 1'($random(seed));
        prioExp = 4'h0;
        ccModel = CORE_CONTROL_RST;
        apb(1'b0, CORE_CONTROL_OFS, 32'h0);
        chk("cc reset", ccView(ccModel, prioExp), rd);
        chk("latency reset", 32'h0, {31'h0, variableLatency});
        chk("nest reset", 32'h0, {31'h0, nestingDisabled});
        apb(1'b0, INTR_CONTROL_ONE_OFS, 32'h0);
        chk("ic1 reset", 32'h0, rd);
        // all ones: read-only fields and the top priority bit must not take them
        apb(1'b1, CORE_CONTROL_OFS, 32'h0000_FFFF);
        ccModel = 16'hFFFF & CORE_CONTROL_WMSK;
        @(negedge clock);
        chk("latency var", 32'h1, {31'h0, variableLatency});
        apb(1'b0, CORE_CONTROL_OFS, 32'h0);
        chk("cc ro", ccView(ccModel, prioExp), rd);
        // priority loads, corner values 7 and 8 first
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : 4'($random(seed));
            loadPrio(v);
            chk("priority", {28'h0, v}, {28'h0, cpuPriority});
            apb(1'b0, CORE_CONTROL_OFS, 32'h0);
            chk("prio top", ccView(ccModel, v), rd);
            apb(1'b0, PROC_STATUS_OFS, 32'h0);
            chk("prio low", {29'h0, v[2:0]}, {29'h0, rd[7:5]});
        end
        loadPrio(4'hC);
        apb(1'b1, CORE_CONTROL_OFS, {16'h0, ccModel | 16'h0008});
        @(negedge clock);
        chk("top kept", 32'hC, {28'h0, cpuPriority});
        ccModel[15] = 1'b0;
        apb(1'b1, CORE_CONTROL_OFS, {16'h0, ccModel});
        @(negedge clock);
        chk("top clear", 32'h4, {28'h0, cpuPriority});
        chk("latency fix", 32'h0, {31'h0, variableLatency});
        // nesting control against a waiting request during service
        loadPrio(4'h3);
        @(posedge clock);
        irqPending <= 1'b1;
        irqLevel   <= 4'h5;
        inService  <= 1'b1;
        apb(1'b1, INTR_CONTROL_ONE_OFS, 32'h0000_8000);
        @(negedge clock);
        chk("nest on", 32'h1, {31'h0, nestingDisabled});
        chk("preempt off", 32'h0, {31'h0, preemptAllowed});
        apb(1'b1, INTR_CONTROL_ONE_OFS, 32'h0);
        @(negedge clock);
        chk("preempt on", 32'h1, {31'h0, preemptAllowed});
        @(posedge clock);
        irqLevel <= 4'h3;
        @(negedge clock);
        chk("preempt equal", 32'h0, {31'h0, preemptAllowed});
        // each trap cause alone; writing 1 keeps it, writing 0 clears it
        for (int k = 0; k < 4; k++)
        begin
            mask = 16'h4000 >> k;
            @(posedge clock);
            trapCause <= 4'b1000 >> k;
            @(posedge clock);
            trapCause <= '0;
            apb(1'b0, INTR_CONTROL_ONE_OFS, 32'h0);
            chk("trap set", {16'h0, mask}, rd);
            apb(1'b1, INTR_CONTROL_ONE_OFS, {16'h0, mask});
            apb(1'b0, INTR_CONTROL_ONE_OFS, 32'h0);
            chk("trap sticky", {16'h0, mask}, rd);
            apb(1'b1, INTR_CONTROL_ONE_OFS, 32'h0);
            apb(1'b0, INTR_CONTROL_ONE_OFS, 32'h0);
            chk("trap clear", 32'h0, rd);
        end
        // mid-run reset with latency on and a flag just set: all returns to reset values
        apb(1'b1, CORE_CONTROL_OFS, 32'h0000_8000);
        @(negedge clock);
        chk("latency set", 32'h1, {31'h0, variableLatency});
        @(posedge clock);
        trapCause <= 4'b1000;
        @(posedge clock);
        trapCause <= '0;
        sys_rst   <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk("latency rerst", 32'h0, {31'h0, variableLatency});
        chk("prio rerst", 32'h0, {28'h0, cpuPriority});
        apb(1'b0, CORE_CONTROL_OFS, 32'h0);
        chk("cc rerst", ccView(CORE_CONTROL_RST, 4'h0), rd);
        apb(1'b0, INTR_CONTROL_ONE_OFS, 32'h0);
        chk("ic1 rerst", 32'h0, rd);
        // unmapped place: refused, reads zero
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk("unmapped wr err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped rd err", 32'h1, {31'h0, err});
        chk("unmapped rd", 32'h0, rd);
        print_verdict();
    end
endmodule
